// ==== rfs_core.sv ====
// rotate, fill and stop execution with four-phase sequencing
`timescale 1ns/1ns
`default_nettype none
`include "rfs_cfg.svh"
module rfs_core
   import rfs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [15:0] instr,
   input wire logic ext_set_en,
   input wire logic [7:0] bank_select_reg,
   input wire logic [7:0] file_rd_data,
   input wire logic wdt_wake,
   input wire logic other_wake,
   output logic [11:0] file_addr,
   output logic file_indexed,
   output logic file_rd,
   output logic file_wr,
   output logic [7:0] file_wr_data,
   output logic acc_wr,
   output logic [7:0] acc_wr_data,
   output logic result_msb_flag,
   output logic result_null_flag,
   output logic power_down_flag,
   output logic timeout_flag,
   output logic wdt_clear,
   output logic [7:0] watchdog_counter,
   output logic sleeping,
   output logic osc_halt,
   output phase_t phase
);
   ////////////////////////////////////////////////////////////////
   rfs_dec_if dbus ();
   op_t op_q;             // instruction latched at Q1
   logic dest_q;          // latched destination
   logic [11:0] addr_q;   // latched full address
   logic idx_q;           // latched indexed mode
   logic [7:0] opnd;      // operand read at Q2
   logic [7:0] result;    // value formed at Q3
   // zero test on a byte
   function automatic logic is_zero(input logic [7:0] v);
      is_zero = (v == `ZERO_BYTE);
   endfunction
   rfs_decoder u_dec (
      .instr(instr),
      .ext_set_en(ext_set_en),
      .d(dbus)
   );
   ////////////////////////////////////////////////////////////////
   // phase ring, held while asleep
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase <= PH_Q1;
      end else if (clk_en && !sleeping) begin
         case (phase)
            PH_Q1: phase <= PH_Q2;
            PH_Q2: phase <= PH_Q3;
            PH_Q3: phase <= PH_Q4;
            default: phase <= PH_Q1;
         endcase
      end
   end
   // decode capture at Q1
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         op_q <= OP_NONE;
         dest_q <= 1'b0;
         addr_q <= 12'h000;
         idx_q <= 1'b0;
      end else if (clk_en && !sleeping && phase == PH_Q1) begin
         op_q <= dbus.op;
         dest_q <= dbus.dest_file;
         idx_q <= dbus.indexed;
         // access bank keeps bank 0, otherwise the bank register
         addr_q <= dbus.bank_sel ? {bank_select_reg[3:0], dbus.addr} : {4'h0, dbus.addr};
      end
   end
   assign file_addr = addr_q;
   assign file_indexed = idx_q;
   // read strobe in Q2 for file instructions; stop reads nothing
   assign file_rd = (phase == PH_Q2) && (op_q == OP_ROT || op_q == OP_FILL) && !sleeping;
   // operand and result registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         opnd <= `ZERO_BYTE;
         result <= `ZERO_BYTE;
      end else if (clk_en && !sleeping) begin
         if (phase == PH_Q2) begin
            opnd <= file_rd_data;
         end
         if (phase == PH_Q3) begin
            if (op_q == OP_FILL) begin
               result <= `ALL_ONES;
            end else begin
               result <= {opnd[0], opnd[7:1]};
            end
         end
      end
   end
   // Q4 writeback strobes, combinational
   assign file_wr = (phase == PH_Q4) && !sleeping &&
                    ((op_q == OP_FILL) || (op_q == OP_ROT && dest_q));
   assign acc_wr = (phase == PH_Q4) && !sleeping && (op_q == OP_ROT) && !dest_q;
   assign file_wr_data = result;
   assign acc_wr_data = result;
   // flags from rotate only
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_msb_flag <= 1'b0;
         result_null_flag <= 1'b0;
      end else if (clk_en && !sleeping && phase == PH_Q4 && op_q == OP_ROT) begin
         result_msb_flag <= result[7];
         result_null_flag <= is_zero(result);
      end
   end
   ////////////////////////////////////////////////////////////////
   // stop handling in Q3 and Q4, and wake
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         power_down_flag <= 1'b1;
         timeout_flag <= 1'b1;
         sleeping <= 1'b0;
      end else if (clk_en) begin
         if (sleeping && (wdt_wake || other_wake)) begin
            sleeping <= 1'b0;
            if (wdt_wake) begin
               timeout_flag <= 1'b0;
            end
         end else if (!sleeping && op_q == OP_STOP && phase == PH_Q3) begin
            power_down_flag <= 1'b0;
            timeout_flag <= 1'b1;
         end else if (!sleeping && op_q == OP_STOP && phase == PH_Q4) begin
            sleeping <= 1'b1;
         end
      end
   end
   assign osc_halt = sleeping;
   assign wdt_clear = !sleeping && (op_q == OP_STOP) && (phase == PH_Q3);
   // local watchdog count, cleared by stop
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         watchdog_counter <= `WDT_CLEAR;
      end else if (clk_en) begin
         if (wdt_clear) begin
            watchdog_counter <= `WDT_CLEAR;
         end else begin
            watchdog_counter <= 8'(watchdog_counter + 8'h01); // carry out dropped on wrap
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   // checks
   sequence stop_q3_s;
      !sleeping && op_q == OP_STOP && phase == PH_Q3 && clk_en;
   endsequence
   rot_value_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && !sleeping && phase == PH_Q3 && op_q == OP_ROT) |=> result == {$past(opnd[0]), $past(opnd[7:1])})
      else $error("rotate result wrong");
   fill_value_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (file_wr && op_q == OP_FILL) |-> file_wr_data == `ALL_ONES && !acc_wr)
      else $error("fill value wrong");
   dest_select_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (phase == PH_Q4 && !sleeping && op_q == OP_ROT) |-> (file_wr == dest_q) && (acc_wr == !dest_q))
      else $error("destination wrong");
   write_phase_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (file_wr || acc_wr) |-> phase == PH_Q4)
      else $error("write outside Q4");
   pd_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      stop_q3_s |=> !power_down_flag)
      else $error("power-down not cleared");
   to_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      stop_q3_s |=> timeout_flag)
      else $error("timeout not set");
   wdt_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      stop_q3_s |=> watchdog_counter == `WDT_CLEAR)
      else $error("watchdog not cleared");
   enter_sleep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      stop_q3_s ##1 clk_en |=> sleeping && osc_halt)
      else $error("sleep not entered");
   wdt_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (sleeping && wdt_wake && clk_en) |=> !timeout_flag && !sleeping)
      else $error("timeout not cleared");
   null_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && !sleeping && phase == PH_Q4 && op_q == OP_ROT) |=> result_null_flag == ($past(result) == `ZERO_BYTE))
      else $error("null flag wrong");
   phase_ring_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && !sleeping && phase == PH_Q1) |=> phase == PH_Q2)
      else $error("phase order wrong");
endmodule
`default_nettype wire

// ==== rfs_cfg.svh ====
// constants for the rotate, fill and stop decode block
//   Function
//   - plain rotate right, old bit 0 to 7
//   - destination bit picks accumulator or file
//   - access bit picks access bank or bank
//   - indexed offset when access 0, extended, <=95
//   - one word, one cycle, four phases
//   - fill writes FFh to file, no flags
//   - fill write happens in last phase
//   - stop clears power-down flag
//   - stop sets timeout flag
//   - stop clears watchdog counter
//   - stop enters low-power state, oscillator halted
//   - stop phases: decode, nop, process, sleep
//   - watchdog wake clears timeout flag
`ifndef RFS_CFG_SVH
`define RFS_CFG_SVH
// opcode patterns in the upper byte; rotate masks the d and a bits, fill masks only the a bit
`define OPC_ROT_MASK 8'hFC
`define OPC_ROT_VAL 8'h40
`define OPC_FILL_MASK 8'hFE
`define OPC_FILL_VAL 8'h68
`define OPC_STOP_WORD 16'h0003
// field positions
`define BIT_DEST 9
`define BIT_ACC 8
`define ALL_ONES 8'hFF
`define ZERO_BYTE 8'h00
`define IDX_LIMIT 8'h5F
`define WDT_CLEAR 8'h00
`endif

// ==== rfs_pkg.sv ====
// types for the rotate, fill and stop decode block
package rfs_pkg;
   // phase of the instruction cycle, one-hot
   typedef enum logic [3:0] {
      PH_Q1 = 4'h1,
      PH_Q2 = 4'h2,
      PH_Q3 = 4'h4,
      PH_Q4 = 4'h8
   } phase_t;
   // decoded instruction kind
   typedef enum logic [1:0] {
      OP_NONE = 2'h0,
      OP_ROT = 2'h1,
      OP_FILL = 2'h2,
      OP_STOP = 2'h3
   } op_t;
endpackage

// ==== rfs_dec_if.sv ====
// decode results carried from the decoder to the executor
`timescale 1ns/1ns
`default_nettype none
interface rfs_dec_if;
   import rfs_pkg::*;
   op_t op;          // decoded kind
   logic dest_file;  // 1 writes file, 0 writes accumulator
   logic [7:0] addr; // file address field
   logic bank_sel;   // 1 uses bank register
   logic indexed;    // indexed literal offset mode
   modport dec (output op, dest_file, addr, bank_sel, indexed);
   modport exe (input op, dest_file, addr, bank_sel, indexed);
endinterface
`default_nettype wire

// ==== rfs_decoder.sv ====
// combinational opcode decoder
`timescale 1ns/1ns
`default_nettype none
`include "rfs_cfg.svh"
module rfs_decoder
   import rfs_pkg::*;
(
   input wire logic [15:0] instr,
   input wire logic ext_set_en,
   rfs_dec_if.dec d
);
   // exact upper-byte match against a masked pattern
   function automatic logic opc_match(input logic [7:0] hi, input logic [7:0] msk, input logic [7:0] val);
      opc_match = ((hi & msk) == val);
   endfunction
   // classify the word
   always_comb begin
      if (instr == `OPC_STOP_WORD) begin
         d.op = OP_STOP;
      end else if (opc_match(instr[15:8], `OPC_ROT_MASK, `OPC_ROT_VAL)) begin
         d.op = OP_ROT;
      end else if (opc_match(instr[15:8], `OPC_FILL_MASK, `OPC_FILL_VAL)) begin
         d.op = OP_FILL;
      end else begin
         d.op = OP_NONE;
      end
   end
   // fill always targets the file register
   assign d.dest_file = (d.op == OP_FILL) ? 1'b1 : instr[`BIT_DEST];
   assign d.addr = instr[7:0];
   assign d.bank_sel = instr[`BIT_ACC];
   assign d.indexed = !instr[`BIT_ACC] && ext_set_en && (instr[7:0] <= `IDX_LIMIT);
endmodule
`default_nettype wire

// ==== rotate_fill_sleep_decode_tb_top.sv ====
// self-checking bench for the rotate, fill and stop core
`timescale 1ns/1ns
`default_nettype none
module rotate_fill_sleep_decode_tb_top
   import rfs_pkg::*;
;
   ////////////////////////////////////////////////////////////////
   // stimulus, observed outputs, expectations
   logic ref_clk, rst_n, clk_en, ext_set_en, wdt_wake, other_wake;
   logic [15:0] instr;
   logic [7:0] bank_select_reg, file_rd_data, file_wr_data, acc_wr_data, watchdog_counter;
   logic [11:0] file_addr;
   logic file_indexed, file_rd, file_wr, acc_wr, wdt_clear, sleeping, osc_halt;
   logic result_msb_flag, result_null_flag, power_down_flag, timeout_flag;
   phase_t phase;
   logic exp_msb = 1'b0; // flag model, moves only on rotate
   logic exp_null = 1'b0;
   int errors = 0, checked = 0, cycles = 0;
   rfs_core uut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .instr(instr), .ext_set_en(ext_set_en),
      .bank_select_reg(bank_select_reg), .file_rd_data(file_rd_data), .wdt_wake(wdt_wake),
      .other_wake(other_wake), .file_addr(file_addr), .file_indexed(file_indexed), .file_rd(file_rd),
      .file_wr(file_wr), .file_wr_data(file_wr_data), .acc_wr(acc_wr), .acc_wr_data(acc_wr_data),
      .result_msb_flag(result_msb_flag), .result_null_flag(result_null_flag),
      .power_down_flag(power_down_flag), .timeout_flag(timeout_flag), .wdt_clear(wdt_clear),
      .watchdog_counter(watchdog_counter), .sleeping(sleeping), .osc_halt(osc_halt), .phase(phase));
   ////////////////////////////////////////////////////////////////
   // compare, step and closing helpers
   task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_val({11'h0, got}, {11'h0, exp});
   endtask
   task automatic step();
      @(posedge ref_clk);
      #1;
   endtask
   task automatic end_of_test();
      if (errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // one instruction, judged phase by phase
   task automatic exec(input logic [15:0] w, input logic [7:0] rd, input logic ext);
      logic rot, fill, stop, d, a;
      logic [7:0] f, res;
      rot = (w[15:10] === 6'h10);
      fill = (w[15:9] === 7'h34);
      stop = (w === 16'h0003);
      d = w[9];
      a = w[8];
      f = w[7:0];
      res = rot ? {rd[0], rd[7:1]} : 8'hFF;
      instr <= w;
      file_rd_data <= rd;
      ext_set_en <= ext;
      step(); // second phase: operand read
      chk_bit(file_rd, rot | fill);
      if (rot | fill) begin
         chk_val(file_addr, a ? {bank_select_reg[3:0], f} : {4'h0, f});
         chk_bit(file_indexed, !a && ext && f <= 8'h5F);
      end
      step(); // third phase
      chk_bit(wdt_clear, stop);
      step(); // last phase: write
      chk_bit(file_wr, fill | (rot & d));
      chk_bit(acc_wr, rot & !d);
      if (rot | fill) chk_val({4'h0, (d | fill) ? file_wr_data : acc_wr_data}, {4'h0, res});
      if (stop) begin
         chk_bit(power_down_flag, 1'b0);
         chk_bit(timeout_flag, 1'b1);
         chk_val({4'h0, watchdog_counter}, 12'h000);
      end
      if (rot) begin
         exp_msb = res[7];
         exp_null = (res === 8'h00);
      end
      step(); // back in decode phase
      chk_bit(result_msb_flag, exp_msb);
      chk_bit(result_null_flag, exp_null);
      chk_bit(sleeping, stop);
      chk_bit(osc_halt, stop);
      if (!stop) chk_val({8'h0, phase}, {8'h0, PH_Q1});
   endtask
   ////////////////////////////////////////////////////////////////
   // asleep: ignore a fill, then wake by one of the two sources
   task automatic wake(input logic by_wdt);
      int n;
      instr <= 16'h68FF;
      repeat (4) begin
         step();
         chk_bit(file_rd | file_wr, 1'b0);
      end
      instr <= 16'h0000;
      wdt_wake <= by_wdt;
      other_wake <= !by_wdt;
      n = 0;
      while (sleeping !== 1'b0 && n < 8) begin
         step();
         n++;
      end
      wdt_wake <= 1'b0;
      other_wake <= 1'b0;
      chk_bit(sleeping, 1'b0);
      chk_bit(timeout_flag, !by_wdt);
      chk_bit(power_down_flag, 1'b0);
      n = 0;
      while (phase !== PH_Q1 && n < 8) begin
         step();
         n++;
      end
   endtask
   // held enable freezes phase and watchdog count
   task automatic stall();
      logic [7:0] wd;
      clk_en <= 1'b0;
      step();
      wd = watchdog_counter;
      repeat (2) step();
      chk_val({8'h0, phase}, {8'h0, PH_Q1});
      chk_val({4'h0, watchdog_counter}, {4'h0, wd});
      clk_en <= 1'b1;
   endtask
   ////////////////////////////////////////////////////////////////
   // clock, hang guard, main sequence
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         errors++;
         end_of_test();
      end
   end
   initial begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      instr = 16'h0000;
      ext_set_en = 1'b0;
      bank_select_reg = 8'hA5;
      file_rd_data = 8'h00;
      wdt_wake = 1'b0;
      other_wake = 1'b0;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      chk_bit(power_down_flag, 1'b1);
      chk_bit(timeout_flag, 1'b1);
      chk_bit(sleeping, 1'b0);
      exec(16'h4220, 8'hD7, 1'b0);
      exec(16'h415F, 8'h00, 1'b1);
      exec(16'h4005, 8'h80, 1'b1);
      exec(16'h4260, 8'h01, 1'b1);
      stall();
      exec(16'h685F, 8'h3C, 1'b1);
      exec(16'h6910, 8'h00, 1'b0);
      exec(16'h3210, 8'h55, 1'b0);
      exec(16'h4410, 8'h55, 1'b0);
      exec(16'h6A10, 8'h55, 1'b0);
      exec(16'h0004, 8'h55, 1'b0);
      exec(16'h0003, 8'h55, 1'b0);
      wake(1'b0);
      exec(16'h0003, 8'h55, 1'b0);
      wake(1'b1);
      exec(16'h4220, 8'hD7, 1'b0);
      end_of_test();
   end
endmodule
`default_nettype wire
